// ### rtl/srsr_top.sv
// status byte, event register sets and service request logic
// Functional notes
// - start a request only on an enabled rising summary bit with none pending
// - a request stays pending until the controller serial-polls the status byte
// - starting a request raises the service request line and request status bit 6
// - serial poll returns the byte, then clears bit 6 only
// - a status byte query returns master summary on bit 6
// - other status bits track live; enable bit 6 reads and acts as zero
// - bit 3 summarises the enabled quality events
// - bit 4 shows a response message waiting in the output queue
// - bit 5 summarises the enabled standard events
// - bit 7 summarises the enabled operation events
// - quality condition bit 0 is overrange, bit 8 converter hardware error
// - standard events: 0 complete, 2 query, 3 device, 4 execution, 5 command, 7 power-on
// - standard set has event and enable only; errors set event bits directly
// - operation condition bits 4 measuring, 5 trigger wait, 6 arm wait, 8 data, 9 block
// - a trigger while the trigger wait bit is zero is ignored
// - unassigned condition and event bits read as zero; enable bits keep what was written except bit 15, standard enable bits 8 to 14, and enable bit 6
// - clear-status empties error queue and zeroes all three event registers
// - clear-status leaves every enable register unchanged
// - condition bits follow their conditions every cycle and are read-only
// - a quality or operation event bit latches on a condition change until read or clear-status
// - summary is the OR of enabled event bits; enables are read-write
// - status byte and standard event are 8 bits; others 16 with bit 15 zero
`timescale 1ns/100ps
`default_nettype none
`include "srsr_defines.svh"

module srsr_top (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rstn,
    // monitored conditions and error sources
    input  wire srsr_pkg::srsr_cond_type   cond_in,
    input  wire srsr_pkg::srsr_err_type    err_in,
    input  wire logic                      msg_available,
    // register access from the command parser
    input  wire logic                      reg_rd,
    input  wire logic                      reg_wr,
    input  wire srsr_pkg::srsr_reg_sel_type reg_sel,
    input  wire logic [15:0]               reg_wdata,
    input  wire logic                      clear_status,
    output logic      [15:0]               reg_rdata,
    output logic                           reg_rvalid,
    output logic                           err_queue_flush,
    // bus side
    input  wire logic                      serial_poll,
    output logic                           srq_line,
    output logic      [7:0]                poll_byte,
    output logic                           poll_valid,
    // trigger gating
    input  wire logic                      trigger_in,
    output logic                           trigger_accept
);
    import srsr_pkg::*;

    logic [15:0] ques_cond_q;
    logic [15:0] oper_cond_q;
    logic [15:0] ques_cond_d;
    logic [15:0] oper_cond_d;
    logic [15:0] std_set;
    logic [15:0] ques_evt;
    logic [15:0] ques_en;
    logic [15:0] std_evt;
    logic [15:0] std_en;
    logic [15:0] oper_evt;
    logic [15:0] oper_en;
    logic        ques_sum;
    logic        std_sum;
    logic        oper_sum;
    logic        power_on_done_q;
    logic [7:0]  stb_live_q;
    logic [7:0]  stb_live_d;
    logic [7:0]  stb_prev_q;
    logic [7:0]  sre_q;
    logic [7:0]  sre_prev_q;
    logic        rqs_q;
    logic        srq_start;
    logic        master_summary_bit;
    logic [15:0] rd_mux;

    // condition bits, unlatched
    always_comb begin
        ques_cond_d = 16'h0000;
        oper_cond_d = 16'h0000;
        ques_cond_d[`SRSR_QC_OVERLOAD]    = cond_in.overload;
        ques_cond_d[`SRSR_QC_ADC_ERR]     = cond_in.adc_error;
        oper_cond_d[`SRSR_OC_MEASURING]   = cond_in.measuring;
        oper_cond_d[`SRSR_OC_WAIT_TRIG]   = cond_in.wait_trig;
        oper_cond_d[`SRSR_OC_WAIT_ARM]    = cond_in.wait_arm;
        oper_cond_d[`SRSR_OC_DATA_READY]  = cond_in.data_ready;
        oper_cond_d[`SRSR_OC_BLOCK_READY] = cond_in.block_ready;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ques_cond_q <= `SRSR_REG_RESET;
            oper_cond_q <= `SRSR_REG_RESET;
        end else begin
            ques_cond_q <= ques_cond_d;
            oper_cond_q <= oper_cond_d;
        end
    end

    // power-on event fires once, on the first clock after reset release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            power_on_done_q <= 1'b0;
        end else begin
            power_on_done_q <= 1'b1;
        end
    end

    // error sources set standard events directly, there is no condition stage
    always_comb begin
        std_set = 16'h0000;
        std_set[`SRSR_SE_OPC]       = err_in.opc;
        std_set[`SRSR_SE_QUERY_ERR] = err_in.query_err;
        std_set[`SRSR_SE_DEV_ERR]   = err_in.dev_err;
        std_set[`SRSR_SE_EXEC_ERR]  = err_in.exec_err;
        std_set[`SRSR_SE_CMD_ERR]   = err_in.cmd_err;
        std_set[`SRSR_SE_POWER_ON]  = !power_on_done_q;
    end

    srsr_event_set #(
        .VALID_MASK (`SRSR_QUES_MASK),
        .EN_MASK    (`SRSR_WIDE_EN_MASK)
    ) u_ques (
        .clock     (clock),
        .rstn      (rstn),
        .set_bits  (ques_cond_d ^ ques_cond_q),
        .clear_evt (clear_status || (reg_rd && reg_sel == SRSR_SEL_QUES_EVT)),
        .en_wr     (reg_wr && reg_sel == SRSR_SEL_QUES_EN),
        .en_wdata  (reg_wdata),
        .evt_q     (ques_evt),
        .en_q      (ques_en),
        .summary   (ques_sum)
    );

    srsr_event_set #(
        .VALID_MASK (`SRSR_STD_MASK),
        .EN_MASK    (`SRSR_STD_EN_MASK)
    ) u_std (
        .clock     (clock),
        .rstn      (rstn),
        .set_bits  (std_set),
        .clear_evt (clear_status || (reg_rd && reg_sel == SRSR_SEL_STD_EVT)),
        .en_wr     (reg_wr && reg_sel == SRSR_SEL_STD_EN),
        .en_wdata  (reg_wdata),
        .evt_q     (std_evt),
        .en_q      (std_en),
        .summary   (std_sum)
    );

    srsr_event_set #(
        .VALID_MASK (`SRSR_OPER_MASK),
        .EN_MASK    (`SRSR_WIDE_EN_MASK)
    ) u_oper (
        .clock     (clock),
        .rstn      (rstn),
        .set_bits  (oper_cond_d ^ oper_cond_q),
        .clear_evt (clear_status || (reg_rd && reg_sel == SRSR_SEL_OPER_EVT)),
        .en_wr     (reg_wr && reg_sel == SRSR_SEL_OPER_EN),
        .en_wdata  (reg_wdata),
        .evt_q     (oper_evt),
        .en_q      (oper_en),
        .summary   (oper_sum)
    );

    // live status byte, bit 6 is carried separately as request status
    always_comb begin
        stb_live_d = 8'h00;
        stb_live_d[`SRSR_SB_QUES] = ques_sum;
        stb_live_d[`SRSR_SB_MAV]  = msg_available;
        stb_live_d[`SRSR_SB_STD]  = std_sum;
        stb_live_d[`SRSR_SB_OPER] = oper_sum;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stb_live_q <= `SRSR_BYTE_RESET;
            stb_prev_q <= `SRSR_BYTE_RESET;
            sre_prev_q <= `SRSR_BYTE_RESET;
        end else begin
            stb_live_q <= stb_live_d;
            stb_prev_q <= stb_live_q;
            sre_prev_q <= sre_q;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sre_q <= `SRSR_BYTE_RESET;
        end else if (reg_wr && reg_sel == SRSR_SEL_SRE) begin
            sre_q <= reg_wdata[7:0] & `SRSR_SRE_MASK;
        end
    end

    // a newly enabled bit that is already set counts as a rising summary too
    assign srq_start = !rqs_q && |((stb_live_q & ~stb_prev_q & sre_q) |
                                   (sre_q & ~sre_prev_q & stb_live_q));
    assign master_summary_bit       = |(stb_live_q & sre_q);

    // pending request; the line is the same flop, so it drops with the poll
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rqs_q <= 1'b0;
        end else if (srq_start) begin
            rqs_q <= 1'b1;
        end else if (serial_poll) begin
            rqs_q <= 1'b0;
        end
    end

    assign srq_line = rqs_q;

    // poll answer holds the request status as it was before the clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            poll_byte  <= `SRSR_BYTE_RESET;
            poll_valid <= 1'b0;
        end else begin
            poll_valid <= serial_poll;
            if (serial_poll) begin
                poll_byte <= stb_live_q | {1'b0, rqs_q, 6'h00};
            end
        end
    end

    always_comb begin
        case (reg_sel)
            SRSR_SEL_STB:       rd_mux = {8'h00, stb_live_q | {1'b0, master_summary_bit, 6'h00}};
            SRSR_SEL_SRE:       rd_mux = {8'h00, sre_q};
            SRSR_SEL_QUES_COND: rd_mux = ques_cond_q;
            SRSR_SEL_QUES_EVT:  rd_mux = ques_evt;
            SRSR_SEL_QUES_EN:   rd_mux = ques_en;
            SRSR_SEL_STD_EVT:   rd_mux = std_evt;
            SRSR_SEL_STD_EN:    rd_mux = std_en;
            SRSR_SEL_OPER_COND: rd_mux = oper_cond_q;
            SRSR_SEL_OPER_EVT:  rd_mux = oper_evt;
            SRSR_SEL_OPER_EN:   rd_mux = oper_en;
            default:            rd_mux = 16'h0000;
        endcase
    end

    // read data registered; event reads clear in the same edge as the capture
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata  <= `SRSR_REG_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux & `SRSR_WIDE_EN_MASK;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            err_queue_flush <= 1'b0;
        end else begin
            err_queue_flush <= clear_status;
        end
    end

    // the decision uses the registered bit the software can also read
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trigger_accept <= 1'b0;
        end else begin
            trigger_accept <= trigger_in && oper_cond_q[`SRSR_OC_WAIT_TRIG];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    srq_start_a: assert property (srq_start |=> rqs_q && srq_line)
        else $error("request not raised on start");
    no_cause_a: assert property (!rqs_q && !srq_start |=> !rqs_q)
        else $error("request raised without cause");
    pending_hold_a: assert property (rqs_q && !serial_poll |=> rqs_q)
        else $error("pending request dropped without poll");
    poll_clear_a: assert property (rqs_q && serial_poll |=> !srq_line && poll_valid && poll_byte[6])
        else $error("poll did not report and clear request");
    poll_others_a: assert property (serial_poll |=> (poll_byte & 8'hbf) == $past(stb_live_q))
        else $error("poll changed other status bits");
    mss_read_a: assert property (reg_rd && reg_sel == SRSR_SEL_STB |=> reg_rdata[6] == $past(master_summary_bit))
        else $error("query bit 6 is not master summary");
    sre_bit6_a: assert property (sre_q[6] == 1'b0)
        else $error("enable bit 6 set");
    ques_sum_a: assert property (stb_live_q[3] == $past(ques_sum))
        else $error("bit 3 wrong");
    mav_track_a: assert property (stb_live_q[4] == $past(msg_available))
        else $error("bit 4 wrong");
    oper_sum_a: assert property (stb_live_q[7] == $past(oper_sum))
        else $error("bit 7 wrong");
    trig_gate_a: assert property (trigger_accept |-> $past(oper_cond_q[5]) && $past(trigger_in))
        else $error("trigger taken while not waiting");
    cond_follow_a: assert property (oper_cond_q[5] == $past(cond_in.wait_trig))
        else $error("condition not live");
    cls_keep_en_a: assert property (clear_status && !reg_wr |=> $stable(ques_en) && $stable(std_en))
        else $error("clear-status altered an enable");
    cls_std_a: assert property (clear_status && std_set == 16'h0000 |=> std_evt == 16'h0000 && err_queue_flush)
        else $error("clear-status left standard events");
    top_bit_a: assert property (reg_rvalid |-> reg_rdata[15] == 1'b0)
        else $error("bit 15 read as one");

    srq_raise_c: cover property (srq_start ##[1:20] serial_poll);
    cls_seen_c: cover property (clear_status && std_evt != 16'h0000);
    trig_take_c: cover property (trigger_accept);
    sre_edge_c: cover property (!rqs_q && (sre_q & ~sre_prev_q & stb_live_q) != 8'h00);

endmodule // srsr_top

`default_nettype wire

// ### rtl/srsr_defines.svh
// bit positions, masks and reset values of the status reporting block
`ifndef SRSR_DEFINES_SVH
`define SRSR_DEFINES_SVH

// status byte bits
`define SRSR_SB_QUES        3
`define SRSR_SB_MAV         4
`define SRSR_SB_STD         5
`define SRSR_SB_RQS         6
`define SRSR_SB_OPER        7
`define SRSR_SB_LIVE_MASK   8'hbf
`define SRSR_SRE_MASK       8'hbf

// quality condition bits
`define SRSR_QC_OVERLOAD    0
`define SRSR_QC_ADC_ERR     8
`define SRSR_QUES_MASK      16'h0101

// operation condition bits
`define SRSR_OC_MEASURING   4
`define SRSR_OC_WAIT_TRIG   5
`define SRSR_OC_WAIT_ARM    6
`define SRSR_OC_DATA_READY  8
`define SRSR_OC_BLOCK_READY 9
`define SRSR_OPER_MASK      16'h0370

// standard event bits
`define SRSR_SE_OPC         0
`define SRSR_SE_QUERY_ERR   2
`define SRSR_SE_DEV_ERR     3
`define SRSR_SE_EXEC_ERR    4
`define SRSR_SE_CMD_ERR     5
`define SRSR_SE_POWER_ON    7
`define SRSR_STD_MASK       16'h00bd

// enable registers: wide sets keep bit 15 at zero
`define SRSR_WIDE_EN_MASK   16'h7fff
`define SRSR_STD_EN_MASK    16'h00ff
`define SRSR_REG_RESET      16'h0000
`define SRSR_BYTE_RESET     8'h00

`endif

// ### rtl/srsr_pkg.sv
// types of the status reporting block
package srsr_pkg;

    typedef enum logic [3:0] {
        SRSR_SEL_STB,
        SRSR_SEL_SRE,
        SRSR_SEL_QUES_COND,
        SRSR_SEL_QUES_EVT,
        SRSR_SEL_QUES_EN,
        SRSR_SEL_STD_EVT,
        SRSR_SEL_STD_EN,
        SRSR_SEL_OPER_COND,
        SRSR_SEL_OPER_EVT,
        SRSR_SEL_OPER_EN
    } srsr_reg_sel_type;

    typedef struct packed {
        logic block_ready;
        logic data_ready;
        logic wait_arm;
        logic wait_trig;
        logic measuring;
        logic adc_error;
        logic overload;
    } srsr_cond_type;

    typedef struct packed {
        logic cmd_err;
        logic exec_err;
        logic dev_err;
        logic query_err;
        logic opc;
    } srsr_err_type;

endpackage

// ### rtl/srsr_event_set.sv
// one latched event register with its enable register and summary
`timescale 1ns/100ps
`default_nettype none
`include "srsr_defines.svh"

module srsr_event_set #(
    parameter logic [15:0] VALID_MASK = 16'hffff,
    parameter logic [15:0] EN_MASK    = 16'hffff
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // event side
    input  wire logic [15:0] set_bits,
    input  wire logic        clear_evt,
    // enable write
    input  wire logic        en_wr,
    input  wire logic [15:0] en_wdata,
    // state
    output logic      [15:0] evt_q,
    output logic      [15:0] en_q,
    output logic             summary
);

    logic [15:0] evt_d;

    // set wins over a read-clear or clear-status in the same cycle
    always_comb begin
        evt_d = ((clear_evt ? 16'h0000 : evt_q) | set_bits) & VALID_MASK;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            evt_q <= `SRSR_REG_RESET;
        end else begin
            evt_q <= evt_d;
        end
    end

    // enables are never touched by clear-status
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            en_q <= `SRSR_REG_RESET;
        end else if (en_wr) begin
            en_q <= en_wdata & EN_MASK;
        end
    end

    assign summary = |(evt_q & en_q);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    evt_sticky_a: assert property (!clear_evt |=> (evt_q & $past(evt_q)) == $past(evt_q))
        else $error("event bit dropped without a clear");
    evt_clear_a: assert property (clear_evt && set_bits == 16'h0000 |=> evt_q == 16'h0000)
        else $error("event register not cleared");
    unused_zero_a: assert property (en_q[15] == 1'b0 && (evt_q & ~VALID_MASK) == 16'h0000)
        else $error("unused event or enable bit set");

endmodule // srsr_event_set

`default_nettype wire

// ### verification/srsr_poll_ctrl.sv
// bus controller model that serial-polls whenever the request line is true
`timescale 1ns/100ps
`default_nettype none

module srsr_poll_ctrl (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // pace set by the bench
    input  wire logic       poll_enable,
    input  wire logic [7:0] poll_delay,
    // bus side
    input  wire logic       srq_line,
    output var  logic       serial_poll
);
    // a slow controller leaves the request pending for poll_delay plus 2 cycles
    initial begin
        serial_poll = 1'b0;
        forever begin
            @(posedge clock);
            if (rstn === 1'b1 && poll_enable === 1'b1 && srq_line === 1'b1) begin
                repeat (poll_delay) @(posedge clock);
                serial_poll <= 1'b1;
                @(posedge clock);
                serial_poll <= 1'b0;
                // the line only drops after the poll edge, so skip past it
                repeat (2) @(posedge clock);
            end
        end
    end
endmodule // srsr_poll_ctrl

`default_nettype wire

// ### verification/srsr_top_bench.sv
// self-checking bench of the status reporting block
`timescale 1ns/100ps
`default_nettype none

module srsr_top_bench;
    import srsr_pkg::*;
    logic             clock;
    logic             rstn;
    srsr_cond_type    cond_in;
    srsr_err_type     err_in;
    logic             msg_available;
    logic             reg_rd;
    logic             reg_wr;
    srsr_reg_sel_type reg_sel;
    logic [15:0]      reg_wdata;
    logic             clear_status;
    logic [15:0]      reg_rdata;
    logic             reg_rvalid;
    logic             err_queue_flush;
    logic             serial_poll;
    logic             srq_line;
    logic [7:0]       poll_byte;
    logic             poll_valid;
    logic             trigger_in;
    logic             trigger_accept;
    logic             poll_enable;
    logic [7:0]       poll_delay;
    int               mismatches;
    int               check_count;
    logic [15:0]      exp_rd[$];
    logic [7:0]       exp_poll[$];

    srsr_top DUT (
        .clock(clock), .rstn(rstn), .cond_in(cond_in), .err_in(err_in),
        .msg_available(msg_available), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_sel(reg_sel), .reg_wdata(reg_wdata), .clear_status(clear_status),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .err_queue_flush(err_queue_flush),
        .serial_poll(serial_poll), .srq_line(srq_line), .poll_byte(poll_byte),
        .poll_valid(poll_valid), .trigger_in(trigger_in), .trigger_accept(trigger_accept)
    );

    srsr_poll_ctrl u_partner (
        .clock(clock), .rstn(rstn), .poll_enable(poll_enable), .poll_delay(poll_delay),
        .srq_line(srq_line), .serial_poll(serial_poll)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
        cmp16(nm, {8'h00, e}, {8'h00, s});
    endtask

    task automatic cmp1(input string nm, input logic e, input logic s);
        cmp16(nm, {15'h0000, e}, {15'h0000, s});
    endtask

    // results are judged here, in the order their notes were queued
    always @(negedge clock) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_rd.size() == 0) cmp1("unexpected reg_rvalid", 1'b0, 1'b1);
            else cmp16("reg_rdata", exp_rd.pop_front(), reg_rdata);
        end
        if (poll_valid === 1'b1) begin
            if (exp_poll.size() == 0) cmp1("unexpected poll_valid", 1'b0, 1'b1);
            else cmp8("poll_byte", exp_poll.pop_front(), poll_byte);
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic rd(input srsr_reg_sel_type s, input logic [15:0] e);
        exp_rd.push_back(e);
        @(posedge clock);
        reg_sel <= s;
        reg_rd  <= 1'b1;
        @(posedge clock);
        reg_rd  <= 1'b0;
    endtask

    task automatic wr(input srsr_reg_sel_type s, input logic [15:0] d);
        @(posedge clock);
        reg_sel   <= s;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic pulse_err(input srsr_err_type v);
        @(posedge clock);
        err_in <= v;
        @(posedge clock);
        err_in <= '0;
    endtask

    task automatic set_cond(input srsr_cond_type c);
        @(posedge clock);
        cond_in <= c;
        idle(4);
    endtask

    task automatic trig(input logic e);
        @(posedge clock);
        trigger_in <= 1'b1;
        @(posedge clock);
        trigger_in <= 1'b0;
        #1 cmp1("trigger_accept", e, trigger_accept);
    endtask

    // bounded wait until every queued poll was answered and the line is free
    task automatic wait_poll;
        int n;
        n = 0;
        while ((exp_poll.size() != 0 || srq_line !== 1'b0) && n < 300) begin
            @(posedge clock);
            n++;
        end
        if (exp_poll.size() != 0 || srq_line !== 1'b0) begin
            mismatches++;
            $display("Error poll wait expected done seen %b", srq_line);
            tally_and_finish;
        end
    endtask

    function automatic logic [15:0] qmap(input srsr_cond_type c);
        qmap = {7'h00, c.adc_error, 7'h00, c.overload};
    endfunction

    function automatic logic [15:0] omap(input srsr_cond_type c);
        omap = {6'h00, c.block_ready, c.data_ready, 1'b0, c.wait_arm, c.wait_trig, c.measuring, 4'h0};
    endfunction

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        $display("Error watchdog expected done seen running");
        tally_and_finish;
    end

    initial begin
        srsr_cond_type    c;
        srsr_cond_type    prev;
        logic [15:0]      v;
        srsr_reg_sel_type en_sel[4];
        logic [15:0]      en_mask[4];
        int               pos[5];
        en_sel  = '{SRSR_SEL_SRE, SRSR_SEL_QUES_EN, SRSR_SEL_STD_EN, SRSR_SEL_OPER_EN};
        en_mask = '{16'h00bf, 16'h7fff, 16'h00ff, 16'h7fff};
        pos     = '{0, 2, 3, 4, 5};
        {rstn, reg_rd, reg_wr, clear_status, msg_available, trigger_in, poll_enable} = '0;
        cond_in = '0;
        err_in = '0;
        reg_sel = SRSR_SEL_STB;
        reg_wdata = '0;
        poll_delay = 8'h14;
        mismatches = 0;
        check_count = 0;
        void'($urandom(32'hca0d4b08));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rd(SRSR_SEL_STD_EVT, 16'h0080);
        rd(SRSR_SEL_STD_EVT, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom());
            wr(en_sel[i], 16'hffff);
            rd(en_sel[i], en_mask[i]);
            wr(en_sel[i], v);
            rd(en_sel[i], v & en_mask[i]);
            wr(en_sel[i], 16'h0000);
        end
        wr(SRSR_SEL_QUES_COND, 16'hffff);
        wr(SRSR_SEL_OPER_COND, 16'hffff);
        rd(SRSR_SEL_QUES_COND, 16'h0000);
        rd(SRSR_SEL_OPER_COND, 16'h0000);
        for (int k = 10; k < 16; k++) rd(srsr_reg_sel_type'(4'(k)), 16'h0000);
        for (int i = 0; i < 5; i++) begin
            pulse_err(srsr_err_type'(5'(1 << i)));
            rd(SRSR_SEL_STD_EVT, 16'(1 << pos[i]));
        end
        // random conditions: events hold the bits that changed since the last read
        prev = '0;
        for (int i = 0; i < 6; i++) begin
            c = srsr_cond_type'(7'($urandom()));
            set_cond(c);
            rd(SRSR_SEL_QUES_COND, qmap(c));
            rd(SRSR_SEL_OPER_COND, omap(c));
            rd(SRSR_SEL_QUES_EVT, qmap(srsr_cond_type'(c ^ prev)));
            rd(SRSR_SEL_OPER_EVT, omap(srsr_cond_type'(c ^ prev)));
            prev = c;
        end
        c = '0;
        set_cond(c);
        trig(1'b0);
        c.wait_trig = 1'b1;
        set_cond(c);
        trig(1'b1);
        c = '0;
        c.overload = 1'b1;
        c.measuring = 1'b1;
        wr(SRSR_SEL_QUES_EN, 16'hffff);
        wr(SRSR_SEL_STD_EN, 16'h00ff);
        wr(SRSR_SEL_OPER_EN, 16'hffff);
        set_cond(c);
        pulse_err(srsr_err_type'(5'h10));
        idle(4);
        rd(SRSR_SEL_STB, 16'h00a8);
        @(posedge clock);
        clear_status <= 1'b1;
        @(posedge clock);
        clear_status <= 1'b0;
        #1 cmp1("err_queue_flush", 1'b1, err_queue_flush);
        idle(4);
        rd(SRSR_SEL_STB, 16'h0000);
        rd(SRSR_SEL_QUES_EVT, 16'h0000);
        rd(SRSR_SEL_STD_EVT, 16'h0000);
        rd(SRSR_SEL_OPER_EVT, 16'h0000);
        rd(SRSR_SEL_QUES_EN, 16'h7fff);
        rd(SRSR_SEL_STD_EN, 16'h00ff);
        // slow controller first, so a second rise lands while the request is pending
        poll_enable <= 1'b1;
        wr(SRSR_SEL_SRE, 16'h0018);
        exp_poll.push_back(8'h58);
        @(posedge clock);
        msg_available <= 1'b1;
        idle(5);
        cmp1("srq_line", 1'b1, srq_line);
        c.overload = 1'b0;
        set_cond(c);
        cmp1("srq_line", 1'b1, srq_line);
        wait_poll;
        idle(10);
        cmp1("srq_line", 1'b0, srq_line);
        rd(SRSR_SEL_STB, 16'h0058);
        poll_delay <= 8'h00;
        rd(SRSR_SEL_QUES_EVT, 16'h0001);
        idle(4);
        exp_poll.push_back(8'h58);
        c.overload = 1'b1;
        set_cond(c);
        wait_poll;
        wr(SRSR_SEL_SRE, 16'h0010);
        exp_poll.push_back(8'h58);
        wr(SRSR_SEL_SRE, 16'h0018);
        idle(4);
        wait_poll;
        msg_available <= 1'b0;
        poll_enable <= 1'b0;
        idle(4);
        cmp1("queues drained", 1'b1, exp_rd.size() == 0 && exp_poll.size() == 0);
        tally_and_finish;
    end
endmodule // srsr_top_bench

`default_nettype wire
